/* File: logic/csr_pkg.sv */
// Shared constants and types for the core special register block
package csr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;

  // Register offsets on the special register port
  localparam logic [7:0] ADDR_STACK_TOP      = 8'h81;
  localparam logic [7:0] ADDR_INDEX_LOW      = 8'h82;
  localparam logic [7:0] ADDR_INDEX_HIGH     = 8'h83;
  localparam logic [7:0] ADDR_STATUS_WORD    = 8'hd0;
  localparam logic [7:0] ADDR_PRIMARY_OPER   = 8'he0;
  localparam logic [7:0] ADDR_SECOND_OPER    = 8'hf0;

  // Reset values
  localparam logic [15:0] RST_INSTR_COUNTER  = 16'h0000;
  localparam logic [7:0]  RST_STACK_TOP      = 8'h07;
  localparam logic [7:0]  RST_STATUS_WORD    = 8'h00;
  localparam logic [7:0]  RST_BYTE           = 8'h00;
  localparam logic [15:0] RST_WORD           = 16'h0000;
  localparam logic [7:0]  RD_UNMAPPED        = 8'h00;

  // Status word field positions
  localparam int BIT_CARRY   = 7;
  localparam int BIT_HALF    = 6;
  localparam int BIT_USER0   = 5;
  localparam int BIT_BANK_HI = 4;
  localparam int BIT_BANK_LO = 3;
  localparam int BIT_WRAP    = 2;
  localparam int BIT_USER1   = 1;
  localparam int BIT_ODD     = 0;

  // Working register bank placement in internal RAM
  localparam int         BANK_BASE_W = 5;
  localparam logic [2:0] BANK_OFFSET = 3'h0;

  // Steps and divide-by-zero answer
  localparam logic [7:0]  STEP_BYTE      = 8'h01;
  localparam logic [15:0] STEP_WORD      = 16'h0001;
  localparam logic [7:0]  DIV_ZERO_QUOT  = 8'hff;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  typedef enum logic [3:0] {
    CSR_OP_NONE,
    CSR_OP_ADD,
    CSR_OP_ADDC,
    CSR_OP_SUBB,
    CSR_OP_MUL,
    CSR_OP_DIV,
    CSR_OP_AND,
    CSR_OP_OR,
    CSR_OP_XOR,
    CSR_OP_LOAD_ACC,
    CSR_OP_INC_INDEX,
    CSR_OP_LOAD_INDEX,
    CSR_OP_PUSH,
    CSR_OP_POP
  } csr_op_t;

endpackage

/* File: logic/csr_alu8.sv */
// Add and subtract with carry, half carry and signed overflow flags
`timescale 1ns/1ps
module csr_alu8
  import csr_pkg::*;
#(
  parameter int W = DATA_W
)
(
  input  logic [W-1:0] i_a,
  input  logic [W-1:0] i_b,
  input  logic         i_sub,
  input  logic         i_cin,
  output logic [W-1:0] o_res,
  output logic         o_cy,
  output logic         o_ac,
  output logic         o_ov
);

  localparam int H = W / 2;

  logic [W-1:0] b_eff;
  logic         c_eff;
  logic [W:0]   full;
  logic [H:0]   half;

  // Subtraction as a + ~b + ~borrow; carry out inverted gives borrow
  always_comb
  begin
    b_eff = i_sub ? ~i_b : i_b;
    c_eff = i_sub ? ~i_cin : i_cin;
    full  = {1'b0, i_a} + {1'b0, b_eff} + {{W{1'b0}}, c_eff};
    half  = {1'b0, i_a[H-1:0]} + {1'b0, b_eff[H-1:0]} + {{H{1'b0}}, c_eff};
    o_res = full[W-1:0];
    o_cy  = full[W] ^ i_sub;
    o_ac  = half[H] ^ i_sub;
    o_ov  = (i_a[W-1] == b_eff[W-1]) && (full[W-1] != i_a[W-1]);
  end

endmodule

/* File: logic/csr_core_regs.sv */
// Core special registers: counter, operands, stack top, status, index
// Overview of operation
// [RULE1] Sixteen-bit instruction counter, not register-mapped, cleared to zero by reset.
// [RULE2] Multiply primary by second operand; low byte to primary, high byte to second.
// [RULE3] Divide primary by second; quotient into primary, remainder into second.
// [RULE4] Stack top resets to 07h, so first push lands at 08h, growing upward.
// [RULE5] Status bits 4 and 3 pick working bank base 00h, 08h, 10h or 18h.
// [RULE6] Carry flag, bit 7, marks carry out of or borrow into top bit.
// [RULE7] Half carry flag, bit 6, marks carry or borrow at bit 3.
// [RULE8] Bit 0 always shows odd count of ones in primary operand.
// [RULE9] Status bits 5 and 1 are software flags that hardware never alters.
// [RULE10] Index word is low byte at 82h and high byte at 83h.
// [RULE11] Index word also loads and increments as one 16-bit quantity.
// [RULE12] Second operand is a plain read/write register outside multiply and divide.
// [RULE13] Primary operand at E0h is source and destination of arithmetic and logic.
// [RULE14] Signed wrap flag, bit 2, marks signed add or subtract overflow.
`timescale 1ns/1ps
module csr_core_regs
  import csr_pkg::*;
(
  input  logic                 i_clk,
  input  logic                 i_rst_n,
  input  logic [ADDR_W-1:0]    i_addr,
  input  logic [DATA_W-1:0]    i_wdata,
  input  logic                 i_wr,
  input  logic                 i_rd,
  output logic [DATA_W-1:0]    o_rdata,
  input  csr_op_t              i_op,
  input  logic [DATA_W-1:0]    i_operand,
  input  logic [WORD_W-1:0]    i_index_value,
  input  logic                 i_pc_advance,
  input  logic                 i_pc_load,
  input  logic [WORD_W-1:0]    i_pc_target,
  output logic [WORD_W-1:0]    o_instr_counter,
  output logic [DATA_W-1:0]    o_primary_operand,
  output logic [DATA_W-1:0]    o_second_operand,
  output logic [DATA_W-1:0]    o_stack_top,
  output logic [DATA_W-1:0]    o_status_word,
  output logic [WORD_W-1:0]    o_data_index,
  output logic [BANK_BASE_W-1:0] o_bank_base
);

  logic [DATA_W-1:0] next_primary;
  logic [DATA_W-1:0] next_second;
  logic [DATA_W-1:0] next_stack_top;
  logic [DATA_W-1:0] next_status;
  logic [WORD_W-1:0] next_index;
  logic [WORD_W-1:0] next_pc;
  logic [DATA_W-1:0] next_rdata;

  logic [DATA_W-1:0] alu_res;
  logic              alu_cy;
  logic              alu_ac;
  logic              alu_ov;
  logic              alu_sub;
  logic              alu_cin;
  logic [WORD_W-1:0] product;

  always_comb
  begin
    alu_sub = (i_op == CSR_OP_SUBB);
    alu_cin = (i_op == CSR_OP_ADD) ? 1'b0 : o_status_word[BIT_CARRY];
  end

  csr_alu8 #(
    .W (DATA_W)
  ) u_alu (
    .i_a   (o_primary_operand),
    .i_b   (i_operand),
    .i_sub (alu_sub),
    .i_cin (alu_cin),
    .o_res (alu_res),
    .o_cy  (alu_cy),
    .o_ac  (alu_ac),
    .o_ov  (alu_ov)
  );

  assign product = WORD_W'(o_primary_operand) * WORD_W'(o_second_operand);

  // Core operation first; a software write in the same cycle overrides it
  always_comb
  begin
    next_primary   = o_primary_operand;
    next_second    = o_second_operand;
    next_stack_top = o_stack_top;
    next_status    = o_status_word;
    next_index     = o_data_index;
    case (i_op)
      CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB:
      begin
        next_primary           = alu_res;                  // see [RULE13]
        next_status[BIT_CARRY] = alu_cy;                   // see [RULE6]
        next_status[BIT_HALF]  = alu_ac;                   // see [RULE7]
        next_status[BIT_WRAP]  = alu_ov;                   // see [RULE14]
      end
      CSR_OP_MUL:
      begin
        next_primary           = product[DATA_W-1:0];      // see [RULE2]
        next_second            = product[WORD_W-1:DATA_W]; // see [RULE2]
        next_status[BIT_CARRY] = 1'b0;
        next_status[BIT_WRAP]  = (product[WORD_W-1:DATA_W] != BYTE_ZERO);
      end
      CSR_OP_DIV:
      begin
        // Zero divisor: quotient saturates, dividend kept as remainder
        next_status[BIT_CARRY] = 1'b0;
        if (o_second_operand == BYTE_ZERO)
        begin
          next_primary          = DIV_ZERO_QUOT;
          next_second           = o_primary_operand;
          next_status[BIT_WRAP] = 1'b1;
        end
        else
        begin
          next_primary          = o_primary_operand / o_second_operand; // see [RULE3]
          next_second           = o_primary_operand % o_second_operand; // see [RULE3]
          next_status[BIT_WRAP] = 1'b0;
        end
      end
      CSR_OP_AND:
      begin
        next_primary = o_primary_operand & i_operand;      // see [RULE13]
      end
      CSR_OP_OR:
      begin
        next_primary = o_primary_operand | i_operand;      // see [RULE13]
      end
      CSR_OP_XOR:
      begin
        next_primary = o_primary_operand ^ i_operand;      // see [RULE13]
      end
      CSR_OP_LOAD_ACC:
      begin
        next_primary = i_operand;
      end
      CSR_OP_INC_INDEX:
      begin
        next_index = o_data_index + STEP_WORD;             // see [RULE11]
      end
      CSR_OP_LOAD_INDEX:
      begin
        next_index = i_index_value;                        // see [RULE11]
      end
      CSR_OP_PUSH:
      begin
        next_stack_top = o_stack_top + STEP_BYTE;          // see [RULE4]
      end
      CSR_OP_POP:
      begin
        next_stack_top = o_stack_top - STEP_BYTE;
      end
      default:
      begin
        next_primary = o_primary_operand;
      end
    endcase
    if (i_wr)
    begin
      if (i_addr == ADDR_STACK_TOP)
      begin
        next_stack_top = i_wdata;
      end
      else if (i_addr == ADDR_INDEX_LOW)
      begin
        next_index[DATA_W-1:0] = i_wdata;                  // see [RULE10]
      end
      else if (i_addr == ADDR_INDEX_HIGH)
      begin
        next_index[WORD_W-1:DATA_W] = i_wdata;             // see [RULE10]
      end
      else if (i_addr == ADDR_STATUS_WORD)
      begin
        next_status = i_wdata;                             // see [RULE9]
      end
      else if (i_addr == ADDR_PRIMARY_OPER)
      begin
        next_primary = i_wdata;
      end
      else if (i_addr == ADDR_SECOND_OPER)
      begin
        next_second = i_wdata;                             // see [RULE12]
      end
    end
    // Parity is never stored from software; it follows the final primary value
    next_status[BIT_ODD] = ^next_primary;                  // see [RULE8]
  end

  // Load wins over advance when both come in one cycle
  always_comb
  begin
    next_pc = o_instr_counter;
    if (i_pc_load)
    begin
      next_pc = i_pc_target;
    end
    else if (i_pc_advance)
    begin
      next_pc = o_instr_counter + STEP_WORD;
    end
  end

  // Read shows the value before any update in the same cycle
  always_comb
  begin
    next_rdata = RD_UNMAPPED;
    if (i_addr == ADDR_STACK_TOP)
    begin
      next_rdata = o_stack_top;
    end
    else if (i_addr == ADDR_INDEX_LOW)
    begin
      next_rdata = o_data_index[DATA_W-1:0];
    end
    else if (i_addr == ADDR_INDEX_HIGH)
    begin
      next_rdata = o_data_index[WORD_W-1:DATA_W];
    end
    else if (i_addr == ADDR_STATUS_WORD)
    begin
      next_rdata = o_status_word;
    end
    else if (i_addr == ADDR_PRIMARY_OPER)
    begin
      next_rdata = o_primary_operand;                      // see [RULE13]
    end
    else if (i_addr == ADDR_SECOND_OPER)
    begin
      next_rdata = o_second_operand;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_instr_counter <= RST_INSTR_COUNTER;                // see [RULE1]
    end
    else
    begin
      o_instr_counter <= next_pc;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_primary_operand <= RST_BYTE;
      o_second_operand  <= RST_BYTE;
    end
    else
    begin
      o_primary_operand <= next_primary;
      o_second_operand  <= next_second;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_stack_top <= RST_STACK_TOP;                        // see [RULE4]
    end
    else
    begin
      o_stack_top <= next_stack_top;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_status_word <= RST_STATUS_WORD;
      o_bank_base   <= {RST_STATUS_WORD[BIT_BANK_HI:BIT_BANK_LO], BANK_OFFSET};
    end
    else
    begin
      o_status_word <= next_status;
      o_bank_base   <= {next_status[BIT_BANK_HI:BIT_BANK_LO], BANK_OFFSET}; // see [RULE5]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_data_index <= RST_WORD;
    end
    else
    begin
      o_data_index <= next_index;
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= RD_UNMAPPED;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : RD_UNMAPPED;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_op_alone(csr_op_t op);
    (i_op == op) && !i_wr;
  endsequence

  a_parity_follows_acc: assert property ( // see [RULE8]
    o_status_word[BIT_ODD] == ^o_primary_operand)
    else $error("parity flag does not match primary operand");

  a_mul_placement: assert property ( // see [RULE2]
    s_op_alone(CSR_OP_MUL) |=>
      {o_second_operand, o_primary_operand} ==
      WORD_W'($past(o_primary_operand)) * WORD_W'($past(o_second_operand)))
    else $error("multiply result misplaced");

  a_div_placement: assert property ( // see [RULE3]
    s_op_alone(CSR_OP_DIV) ##0 (o_second_operand != BYTE_ZERO) |=>
      (o_primary_operand == $past(o_primary_operand) / $past(o_second_operand)) &&
      (o_second_operand == $past(o_primary_operand) % $past(o_second_operand)))
    else $error("divide quotient or remainder wrong");

  a_stack_push_up: assert property ( // see [RULE4]
    s_op_alone(CSR_OP_PUSH) |=> o_stack_top == $past(o_stack_top) + STEP_BYTE)
    else $error("push did not raise stack top by one");

  a_bank_base_map: assert property ( // see [RULE5]
    o_bank_base == {o_status_word[BIT_BANK_HI:BIT_BANK_LO], BANK_OFFSET})
    else $error("bank base does not follow bank select bits");

  a_add_carry_out: assert property ( // see [RULE6]
    s_op_alone(CSR_OP_ADD) |=> o_status_word[BIT_CARRY] ==
      ((9'($past(o_primary_operand)) + 9'($past(i_operand))) > 9'h0ff))
    else $error("carry flag wrong after add");

  a_add_half_carry: assert property ( // see [RULE7]
    s_op_alone(CSR_OP_ADD) |=> o_status_word[BIT_HALF] ==
      ((5'($past(o_primary_operand[3:0])) + 5'($past(i_operand[3:0]))) > 5'h0f))
    else $error("half carry flag wrong after add");

  a_user_flags_kept: assert property ( // see [RULE9]
    (i_op != CSR_OP_NONE) && !(i_wr && (i_addr == ADDR_STATUS_WORD)) |=>
      $stable(o_status_word[BIT_USER0]) && $stable(o_status_word[BIT_USER1]))
    else $error("hardware changed a user flag");

  a_index_increment: assert property ( // see [RULE11]
    s_op_alone(CSR_OP_INC_INDEX) |=> o_data_index == $past(o_data_index) + STEP_WORD)
    else $error("index word did not step as 16 bits");

  a_read_one_cycle: assert property ( // see [RULE13]
    i_rd && (i_addr == ADDR_PRIMARY_OPER) |=> o_rdata == $past(o_primary_operand) ##1
      (o_rdata == RD_UNMAPPED || $past(i_rd)))
    else $error("read data not held for exactly one cycle");

  a_pc_advance: assert property ( // see [RULE1]
    i_pc_advance && !i_pc_load |=> o_instr_counter == $past(o_instr_counter) + STEP_WORD)
    else $error("instruction counter did not advance");

endmodule

/* File: verification/csr_core_regs_tb.sv */
// Self-checking bench for the core special register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module csr_core_regs_tb
  import csr_pkg::*;
;
  typedef struct packed {
    csr_op_t    op;
    logic [7:0] s, a, b, d, ea, eb, es, m;
  } csr_tb_row_t;

  logic              i_clk;
  logic              i_rst_n;
  logic [7:0]        i_addr;
  logic [7:0]        i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [7:0]        o_rdata;
  csr_op_t           i_op;
  logic [7:0]        i_operand;
  logic [15:0]       i_index_value;
  logic              i_pc_advance;
  logic              i_pc_load;
  logic [15:0]       i_pc_target;
  logic [15:0]       o_instr_counter;
  logic [7:0]        o_primary_operand;
  logic [7:0]        o_second_operand;
  logic [7:0]        o_stack_top;
  logic [7:0]        o_status_word;
  logic [15:0]       o_data_index;
  logic [4:0]        o_bank_base;
  int                err_total;
  int                check_count;
  csr_tb_row_t       rows [0:15];
  logic [7:0]        addrs [0:4];

  csr_core_regs u_csr_core_regs (
    .i_clk             (i_clk),
    .i_rst_n           (i_rst_n),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .o_rdata           (o_rdata),
    .i_op              (i_op),
    .i_operand         (i_operand),
    .i_index_value     (i_index_value),
    .i_pc_advance      (i_pc_advance),
    .i_pc_load         (i_pc_load),
    .i_pc_target       (i_pc_target),
    .o_instr_counter   (o_instr_counter),
    .o_primary_operand (o_primary_operand),
    .o_second_operand  (o_second_operand),
    .o_stack_top       (o_stack_top),
    .o_status_word     (o_status_word),
    .o_data_index      (o_data_index),
    .o_bank_base       (o_bank_base)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic conclude();
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Each access leaves one idle edge so no strobe is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic op(input csr_op_t o, input logic [7:0] d);
    @(posedge i_clk);
    i_op      <= o;
    i_operand <= d;
    @(posedge i_clk);
    i_op      <= CSR_OP_NONE;
    #1;
  endtask

  initial
  begin
    #(4 * 5000);
    err_total++;
    conclude();
  end

  initial
  begin
    logic [7:0] v;
    err_total = 0;
    check_count = 0;
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_op = CSR_OP_NONE;
    i_operand = 8'h00;
    i_index_value = 16'h0000;
    i_pc_advance = 1'b0;
    i_pc_load = 1'b0;
    i_pc_target = 16'h0000;
    // Preloaded status, primary, second, operand; expected primary, second, masked status
    rows = '{
      '{CSR_OP_ADD,      8'h00, 8'h0f, 8'h5a, 8'h01, 8'h10, 8'h5a, 8'h41, 8'hc5},
      '{CSR_OP_ADD,      8'h00, 8'hff, 8'h5a, 8'h01, 8'h00, 8'h5a, 8'hc0, 8'hc5},
      '{CSR_OP_ADD,      8'h00, 8'h7f, 8'h5a, 8'h01, 8'h80, 8'h5a, 8'h45, 8'hc5},
      '{CSR_OP_ADD,      8'h22, 8'h01, 8'h5a, 8'h01, 8'h02, 8'h5a, 8'h23, 8'hff},
      '{CSR_OP_ADDC,     8'h80, 8'h01, 8'h5a, 8'h01, 8'h03, 8'h5a, 8'h00, 8'hc5},
      '{CSR_OP_SUBB,     8'h00, 8'h00, 8'h5a, 8'h01, 8'hff, 8'h5a, 8'hc0, 8'hc5},
      '{CSR_OP_SUBB,     8'h00, 8'h80, 8'h5a, 8'h01, 8'h7f, 8'h5a, 8'h45, 8'hc5},
      '{CSR_OP_SUBB,     8'h80, 8'h10, 8'h5a, 8'h00, 8'h0f, 8'h5a, 8'h40, 8'hc5},
      '{CSR_OP_MUL,      8'h00, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h04, 8'h85},
      '{CSR_OP_MUL,      8'h00, 8'hff, 8'hff, 8'h00, 8'h01, 8'hfe, 8'h05, 8'h85},
      '{CSR_OP_MUL,      8'h00, 8'h03, 8'h04, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h85},
      '{CSR_OP_DIV,      8'h00, 8'hfb, 8'h0a, 8'h00, 8'h19, 8'h01, 8'h01, 8'h85},
      '{CSR_OP_DIV,      8'h00, 8'hfb, 8'h00, 8'h00, 8'hff, 8'hfb, 8'h04, 8'h85},
      '{CSR_OP_AND,      8'h00, 8'hca, 8'h5a, 8'h0f, 8'h0a, 8'h5a, 8'h00, 8'hc5},
      '{CSR_OP_OR,       8'h00, 8'hca, 8'h5a, 8'h0f, 8'hcf, 8'h5a, 8'h00, 8'hc5},
      '{CSR_OP_XOR,      8'h00, 8'hca, 8'h5a, 8'h0f, 8'hc5, 8'h5a, 8'h00, 8'hc5}
    };
    addrs = '{8'h81, 8'h82, 8'h83, 8'hf0, 8'he0};
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    `CHK("counter", 16'h0000, o_instr_counter)
    `CHK("stack", 8'h07, o_stack_top)
    `CHK("status", 8'h00, o_status_word)
    op(CSR_OP_PUSH, 8'h00);
    `CHK("push", 8'h08, o_stack_top)
    op(CSR_OP_POP, 8'h00);
    `CHK("pop", 8'h07, o_stack_top)
    // Two back-to-back advances, then a load that must beat advance
    @(posedge i_clk);
    i_pc_advance <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_pc_advance <= 1'b0;
    #1 `CHK("counter", 16'h0002, o_instr_counter)
    @(posedge i_clk);
    i_pc_load <= 1'b1;
    i_pc_advance <= 1'b1;
    i_pc_target <= 16'habcd;
    @(posedge i_clk);
    i_pc_load <= 1'b0;
    i_pc_advance <= 1'b0;
    #1 `CHK("counter", 16'habcd, o_instr_counter)
    for (int i = 0; i < 5; i++)
    begin
      wr(addrs[i], addrs[i] ^ 8'ha5);
      rd(addrs[i], v);
      `CHK("read", addrs[i] ^ 8'ha5, v)
      @(posedge i_clk);
      #1 `CHK("rdata idle", 8'h00, o_rdata)
    end
    `CHK("index", 16'h2627, o_data_index)
    `CHK("second", 8'h55, o_second_operand)
    wr(8'h84, 8'h77);
    rd(8'h84, v);
    `CHK("unmapped", 8'h00, v)
    // Primary now 45h, three ones: parity reads back set over a cleared write
    for (int c = 0; c < 4; c++)
    begin
      wr(8'hd0, {3'h0, 2'(c), 3'h0});
      rd(8'hd0, v);
      `CHK("status", {3'h0, 2'(c), 3'h1}, v)
      `CHK("bank", {2'(c), 3'h0}, o_bank_base)
    end
    for (int r = 0; r < 16; r++)
    begin
      wr(8'he0, rows[r].a);
      wr(8'hf0, rows[r].b);
      wr(8'hd0, rows[r].s);
      op(rows[r].op, rows[r].d);
      `CHK("primary", rows[r].ea, o_primary_operand)
      `CHK("second", rows[r].eb, o_second_operand)
      `CHK("status", rows[r].es, o_status_word & rows[r].m)
    end
    op(CSR_OP_LOAD_ACC, 8'h07);
    `CHK("parity", 8'h01, o_status_word & 8'h01)
    @(posedge i_clk);
    i_index_value <= 16'h12ff;
    op(CSR_OP_LOAD_INDEX, 8'h00);
    op(CSR_OP_INC_INDEX, 8'h00);
    `CHK("index", 16'h1300, o_data_index)
    rd(8'h83, v);
    `CHK("index high", 8'h13, v)
    // Reset in mid-run must act without waiting for an edge
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    #1 `CHK("counter", 16'h0000, o_instr_counter)
    `CHK("stack", 8'h07, o_stack_top)
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // First edges after release keep reset state, then an op lands normally
    #1 `CHK("counter", 16'h0000, o_instr_counter)
    op(CSR_OP_PUSH, 8'h00);
    `CHK("push after reset", 8'h08, o_stack_top)
    `CHK("counter idle", 16'h0000, o_instr_counter)
    conclude();
  end
endmodule
